// [include/fpu_ctl_map.vh]
// Purpose: Constants for the coprocessor control, condition and exception block
// Assumes: Included by bare name from rtl files
// Notes: Definitions only
`ifndef FPU_CTL_MAP_VH
`define FPU_CTL_MAP_VH

// Exception bit positions, shared by flags and masks
`define EXC_INVALID 0
`define EXC_DENORM 1
`define EXC_ZDIV 2
`define EXC_OVFL 3
`define EXC_UNFL 4
`define EXC_INEXACT 5
`define EXC_COUNT 6

// Control word fields
`define CW_GLOBAL_MASK 7
`define CW_PREC_LO 8
`define CW_PREC_HI 9
`define CW_ROUND_LO 10
`define CW_ROUND_HI 11
`define CW_CLOSURE 12
`define CW_RESET_VAL 16'h033F

// Status word fields
`define SW_IRQ 7
`define SW_COND0 8
`define SW_COND1 9
`define SW_COND2 10
`define SW_COND3 14

// Rounding encodings
`define RND_NEAREST 2'h0
`define RND_DOWN 2'h1
`define RND_UP 2'h2
`define RND_CHOP 2'h3

// Precision encodings
`define PREC_SINGLE 2'h0
`define PREC_DOUBLE 2'h2
`define PREC_EXTENDED 2'h3

// Condition update operations
`define CC_OP_NONE 3'h0
`define CC_OP_COMPARE 3'h1
`define CC_OP_EXAMINE 3'h2
`define CC_OP_REMAINDER 3'h3

// Compare outcomes
`define CMP_GREATER 2'h0
`define CMP_LESS 2'h1
`define CMP_EQUAL 2'h2
`define CMP_UNORDERED 2'h3

// Examine operand classes
`define CLS_UNNORMAL 3'h0
`define CLS_NORMAL 3'h1
`define CLS_ZERO_EXP 3'h2
`define CLS_INFINITY 3'h3
`define CLS_ZERO 3'h4
`define CLS_EMPTY 3'h5
`define CLS_ZERO_EXP_Z 3'h6

// Remainder dividend ranges
`define REM_BELOW_2 2'h0
`define REM_BELOW_4 2'h1
`define REM_AT_LEAST_4 2'h2

`endif

// [rtl/cond_code_encoder.v]
// Purpose: Computes next condition flags for compare, examine and remainder
// Assumes: Combinational; previous flags supplied by the caller
// Notes: Flags ordered {three, two, one, zero}
`timescale 1ns/10ps
`include "fpu_ctl_map.vh"

module cond_code_encoder (
  op,
  cmp_result,
  exam_class,
  exam_sign,
  rem_complete,
  rem_range,
  quotient_bit_high,
  quotient_bit_mid,
  quotient_bit_low,
  cc_prev,
  cc_next
);
  input wire [2:0] op;
  input wire [1:0] cmp_result;
  input wire [2:0] exam_class;
  input wire exam_sign;
  input wire rem_complete;
  input wire [1:0] rem_range;
  input wire quotient_bit_high;
  input wire quotient_bit_mid;
  input wire quotient_bit_low;
  input wire [3:0] cc_prev;
  output reg [3:0] cc_next;

  reg q_high;
  reg q_mid;

  always @* begin
    cc_next = cc_prev;
    q_high = quotient_bit_high;
    q_mid = quotient_bit_mid;
    case (op)
      `CC_OP_COMPARE: begin
        case (cmp_result)
          `CMP_GREATER: cc_next = {1'b0, 1'b0, cc_prev[1], 1'b0};
          `CMP_LESS: cc_next = {1'b0, 1'b0, cc_prev[1], 1'b1};
          `CMP_EQUAL: cc_next = {1'b1, 1'b0, cc_prev[1], 1'b0};
          default: cc_next = {1'b1, 1'b1, cc_prev[1], 1'b1};
        endcase
      end
      `CC_OP_EXAMINE: begin
        case (exam_class)
          `CLS_UNNORMAL: cc_next = {1'b0, 1'b0, exam_sign, 1'b0};
          `CLS_ZERO_EXP: cc_next = {1'b0, 1'b0, exam_sign, 1'b1};
          `CLS_NORMAL: cc_next = {1'b0, 1'b1, exam_sign, 1'b0};
          `CLS_INFINITY: cc_next = {1'b0, 1'b1, exam_sign, 1'b1};
          `CLS_ZERO: cc_next = {1'b1, 1'b0, exam_sign, 1'b0};
          `CLS_ZERO_EXP_Z: cc_next = {1'b1, 1'b1, exam_sign, 1'b0};
          default: cc_next = {1'b1, 1'b0, 1'b0, 1'b1};
        endcase
      end
      `CC_OP_REMAINDER: begin
        if (rem_complete) begin
          // Small dividends cannot produce the upper quotient bits
          if (rem_range != `REM_AT_LEAST_4) begin
            q_high = cc_prev[0];
          end
          if (rem_range == `REM_BELOW_2) begin
            q_mid = cc_prev[3];
          end
          cc_next = {q_mid, 1'b0, quotient_bit_low, q_high};
        end else begin
          // Other flags are undefined; holding them is the cheapest choice
          cc_next = {cc_prev[3], 1'b1, cc_prev[1], cc_prev[0]};
        end
      end
      default: cc_next = cc_prev;
    endcase
  end
endmodule

// [rtl/exc_responder.v]
// Purpose: Decides masked default response for one exception class
// Assumes: Combinational, one instance per class
// Notes: Response code meaning depends on the class index
`timescale 1ns/10ps

module exc_responder (
  detected,
  mask,
  flag_set,
  use_default,
  want_trap
);
  input wire detected;
  input wire mask;
  output wire flag_set;
  output wire use_default;
  output wire want_trap;

  assign flag_set = detected;
  assign use_default = detected & mask;
  assign want_trap = detected & ~mask;
endmodule

// [rtl/fpu_control_exception_flags.v]
// Purpose: Control word, condition flags, exception flags and pointer capture
// Assumes: Datapath reports each finished instruction with a one-cycle strobe
// Notes: Control word is loaded and read, status word only read, as whole words
`timescale 1ns/10ps
`include "fpu_ctl_map.vh"

// Contract
// - Each executed numeric instruction saves instruction address and opcode; operand address only when operand_valid is set.
// - Compare or test sets flags three, two and zero by outcome, flag one unchanged.
// - Complete remainder clears flag two, maps quotient bits; incomplete sets flag two.
// - Small dividends keep previous flags for upper quotient bits.
// - Examine with flag three clear encodes class and sign as listed.
// - Examine with flag three set encodes zeros, zero-exponent, empty.
// - Options are loaded as a full control word; low byte exceptions, high mode.
// - Control bits five to zero mask classes; bit seven masks all interrupts.
// - Control bits nine and eight select precision, default extended.
// - Control bits eleven and ten select rounding mode.
// - A control bit selects affine or projective infinity closure.
// - Unmasked exception with interrupts enabled raises an interrupt request.
// - With interrupts disabled execution continues regardless of pending exceptions.
// - Masked exception records flag, applies default response, continues.
// - Invalid operation flagged; masked default gives quiet NaN or propagates NaN.
// - Overflow flagged; masked default gives infinity.
// - Zero divisor flagged; masked default gives infinity.
// - Underflow flagged; masked default denormalizes the result.
// - Denormal operand flagged; masked continues normally.
// - Inexact rounds by selected mode and flags; masked continues.
// - Status bit seven is set when any unmasked flag is set.
// - Status bits five to zero hold sticky exception flags.
module fpu_control_exception_flags #(
  parameter ADDR_W = 20,
  parameter OPC_W = 11
) (
  clk,
  rst_n,
  cw_load,
  cw_load_data,
  cw_value,
  sw_value,
  exc_clear,
  instr_done,
  instr_addr,
  operand_addr,
  operand_valid,
  instr_opcode,
  exc_detected,
  nan_operand,
  cc_op,
  cmp_result,
  exam_class,
  exam_sign,
  rem_complete,
  rem_range,
  quotient_bit_high,
  quotient_bit_mid,
  quotient_bit_low,
  instr_ptr,
  data_ptr,
  opcode_ptr,
  round_mode,
  precision_mode,
  affine_closure,
  resp_nan_sel,
  resp_nan_propagate,
  resp_infinity,
  resp_denormalize,
  resp_round,
  exec_stall,
  int_req
);
  input wire clk;
  input wire rst_n;
  input wire cw_load;
  input wire [15:0] cw_load_data;
  output wire [15:0] cw_value;
  output wire [15:0] sw_value;
  input wire exc_clear;
  input wire instr_done;
  input wire [ADDR_W-1:0] instr_addr;
  input wire [ADDR_W-1:0] operand_addr;
  input wire operand_valid;
  input wire [OPC_W-1:0] instr_opcode;
  input wire [5:0] exc_detected;
  input wire nan_operand;
  input wire [2:0] cc_op;
  input wire [1:0] cmp_result;
  input wire [2:0] exam_class;
  input wire exam_sign;
  input wire rem_complete;
  input wire [1:0] rem_range;
  input wire quotient_bit_high;
  input wire quotient_bit_mid;
  input wire quotient_bit_low;
  output reg [ADDR_W-1:0] instr_ptr;
  output reg [ADDR_W-1:0] data_ptr;
  output reg [OPC_W-1:0] opcode_ptr;
  output wire [1:0] round_mode;
  output wire [1:0] precision_mode;
  output wire affine_closure;
  output reg resp_nan_sel;
  output reg resp_nan_propagate;
  output reg resp_infinity;
  output reg resp_denormalize;
  output reg resp_round;
  output wire exec_stall;
  output reg int_req;

  reg [15:0] numeric_control_word_r;
  reg [5:0] exc_flags_r;
  reg [5:0] exc_flags_nxt;
  reg [3:0] cond_flags_r;
  wire [3:0] cond_flags_nxt;
  wire [5:0] flag_set;
  wire [5:0] use_default;
  wire [5:0] want_trap;
  wire irq_pending;
  wire [5:0] class_mask;
  wire global_mask;

  assign class_mask = numeric_control_word_r[`EXC_COUNT-1:0];
  assign global_mask = numeric_control_word_r[`CW_GLOBAL_MASK];
  assign precision_mode = numeric_control_word_r[`CW_PREC_HI:`CW_PREC_LO];
  assign round_mode = numeric_control_word_r[`CW_ROUND_HI:`CW_ROUND_LO];
  assign affine_closure = numeric_control_word_r[`CW_CLOSURE];
  assign cw_value = numeric_control_word_r;

  // Control word is loaded only as a whole word
  always @(posedge clk) begin
    if (!rst_n) begin
      numeric_control_word_r <= `CW_RESET_VAL;
    end else if (cw_load) begin
      numeric_control_word_r <= cw_load_data;
    end
  end

  // One responder per class; bit order fixed by the shared constants
  genvar gi;
  generate
    for (gi = 0; gi < `EXC_COUNT; gi = gi + 1) begin : g_resp
      exc_responder u_resp (
        .detected(exc_detected[gi] & instr_done),
        .mask(class_mask[gi]),
        .flag_set(flag_set[gi]),
        .use_default(use_default[gi]),
        .want_trap(want_trap[gi])
      );
    end
  endgenerate

  // Sticky flags: a new detection wins over a simultaneous clear
  always @* begin
    exc_flags_nxt = exc_flags_r;
    if (exc_clear) begin
      exc_flags_nxt = 6'h00;
    end
    exc_flags_nxt = exc_flags_nxt | flag_set;
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      exc_flags_r <= 6'h00;
    end else begin
      exc_flags_r <= exc_flags_nxt;
    end
  end

  assign irq_pending = |(exc_flags_r & ~class_mask);

  // Request is registered; the global mask blocks it but not the status bit
  always @(posedge clk) begin
    if (!rst_n) begin
      int_req <= 1'b0;
    end else begin
      int_req <= (|(exc_flags_nxt & ~class_mask)) & ~global_mask;
    end
  end

  // No stall is ever raised from exceptions; the host handles traps
  assign exec_stall = 1'b0;

  // Default responses, one cycle after the instruction finishes; resp_round ignores the inexact mask
  always @(posedge clk) begin
    if (!rst_n) begin
      resp_nan_sel <= 1'b0;
      resp_nan_propagate <= 1'b0;
      resp_infinity <= 1'b0;
      resp_denormalize <= 1'b0;
      resp_round <= 1'b0;
    end else begin
      resp_nan_sel <= use_default[`EXC_INVALID] & ~nan_operand;
      resp_nan_propagate <= use_default[`EXC_INVALID] & nan_operand;
      resp_infinity <= use_default[`EXC_OVFL] | use_default[`EXC_ZDIV];
      resp_denormalize <= use_default[`EXC_UNFL];
      // Denormal default is plain continuation, so it needs no response line
      resp_round <= instr_done & exc_detected[`EXC_INEXACT];
    end
  end

  cond_code_encoder u_cc (
    .op(instr_done ? cc_op : `CC_OP_NONE),
    .cmp_result(cmp_result),
    .exam_class(exam_class),
    .exam_sign(exam_sign),
    .rem_complete(rem_complete),
    .rem_range(rem_range),
    .quotient_bit_high(quotient_bit_high),
    .quotient_bit_mid(quotient_bit_mid),
    .quotient_bit_low(quotient_bit_low),
    .cc_prev(cond_flags_r),
    .cc_next(cond_flags_nxt)
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      cond_flags_r <= 4'h0;
    end else begin
      cond_flags_r <= cond_flags_nxt;
    end
  end

  // Pointers keep the last numeric instruction for error handlers
  always @(posedge clk) begin
    if (!rst_n) begin
      instr_ptr <= {ADDR_W{1'b0}};
      data_ptr <= {ADDR_W{1'b0}};
      opcode_ptr <= {OPC_W{1'b0}};
    end else if (instr_done) begin
      instr_ptr <= instr_addr;
      opcode_ptr <= instr_opcode;
      if (operand_valid) begin
        data_ptr <= operand_addr;
      end
    end
  end

  assign sw_value = {1'b0, cond_flags_r[3], 3'h0, cond_flags_r[2], cond_flags_r[1],
                     cond_flags_r[0], irq_pending, 1'b0, exc_flags_r};
endmodule

// [testbench/fpu_control_exception_flags_tb.sv]
// Purpose: Self-checking bench for control, condition and exception block
// Assumes: Inputs change 2 ns after the rising edge
// Notes: Expected state kept in ecw, eflg and ecc
`timescale 1ns/10ps
module fpu_control_exception_flags_tb;
  logic clk, rst_n, instr_done, operand_valid, nan_operand, exam_sign, rem_complete;
  logic quotient_bit_high, quotient_bit_mid, quotient_bit_low, cw_load, exc_clear;
  logic affine_closure, resp_nan_sel, resp_nan_propagate, resp_infinity;
  logic resp_denormalize, resp_round, exec_stall, int_req;
  logic [19:0] instr_addr, operand_addr, instr_ptr, data_ptr, edp;
  logic [10:0] instr_opcode, opcode_ptr;
  logic [5:0] exc_detected, eflg, m;
  logic [2:0] cc_op, exam_class;
  logic [1:0] cmp_result, rem_range, round_mode, precision_mode;
  logic [15:0] cw_value, sw_value, ecw, cw_load_data;
  logic [3:0] ecc;
  logic [31:0] seed, r;
  int errors, n_checks, i;

  fpu_control_exception_flags #(.ADDR_W(20), .OPC_W(11)) uut (.clk, .rst_n, .cw_load,
    .cw_load_data, .cw_value, .sw_value, .exc_clear, .instr_done, .instr_addr,
    .operand_addr, .operand_valid, .instr_opcode, .exc_detected, .nan_operand, .cc_op,
    .cmp_result, .exam_class, .exam_sign, .rem_complete, .rem_range, .quotient_bit_high,
    .quotient_bit_mid, .quotient_bit_low, .instr_ptr, .data_ptr, .opcode_ptr, .round_mode,
    .precision_mode, .affine_closure, .resp_nan_sel, .resp_nan_propagate, .resp_infinity,
    .resp_denormalize, .resp_round, .exec_stall, .int_req);
  host_model host (.clk, .cw_load, .cw_load_data, .exc_clear);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function [31:0] rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
    end
  endfunction

  function [3:0] nxt_cc(input [3:0] p);
    begin
      nxt_cc = p;
      if (cc_op == 3'h1)
        nxt_cc = {cmp_result[1], &cmp_result, p[1], cmp_result[0]};
      if (cc_op == 3'h2) begin
        case (exam_class)
          3'h0: nxt_cc = {2'b00, exam_sign, 1'b0};
          3'h1: nxt_cc = {2'b01, exam_sign, 1'b0};
          3'h2: nxt_cc = {2'b00, exam_sign, 1'b1};
          3'h3: nxt_cc = {2'b01, exam_sign, 1'b1};
          3'h4: nxt_cc = {2'b10, exam_sign, 1'b0};
          3'h5: nxt_cc = 4'h9;
          default: nxt_cc = {2'b11, exam_sign, 1'b0};
        endcase
      end
      if (cc_op == 3'h3) begin
        nxt_cc[2] = !rem_complete;
        if (rem_complete) begin
          nxt_cc[1] = quotient_bit_low;
          if (rem_range != 2'h0) nxt_cc[3] = quotient_bit_mid;
          if (rem_range == 2'h2) nxt_cc[0] = quotient_bit_high;
        end
      end
    end
  endfunction

  task chk(input [19:0] g, input [19:0] e, input [63:0] nm);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        errors = errors + 1;
        $display("[FAIL] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task ld(input [15:0] d);
    begin
      host.load(d);
      ecw = d;
      chk(cw_value, d, "cw");
      chk({affine_closure, round_mode, precision_mode}, d[12:8], "mode");
      @(posedge clk);
      #2 chk(int_req, |(eflg & ~d[5:0]) & ~d[7], "irq_ld");
    end
  endtask

  task clr;
    begin
      host.clr;
      eflg = 6'h00;
      chk(sw_value[5:0], 6'h00, "clr");
      chk(int_req, 1'b0, "irq_clr");
    end
  endtask

  task go;
    begin
      r = rnd();
      instr_addr = r[19:0];
      operand_addr = ~r[19:0];
      operand_valid = r[31];
      instr_opcode = r[30:20];
      if (r[31]) edp = ~r[19:0];
      ecc = nxt_cc(ecc);
      m = exc_detected & ecw[5:0];
      eflg = eflg | exc_detected;
      instr_done = 1'b1;
      @(posedge clk);
      #2 instr_done = 1'b0;
      chk(instr_ptr, r[19:0], "iptr");
      chk(opcode_ptr, r[30:20], "opc");
      chk(data_ptr, edp, "dptr");
      chk({sw_value[14], sw_value[10:8]}, ecc, "cc");
      chk(sw_value[5:0], eflg, "flags");
      chk(sw_value[7], |(eflg & ~ecw[5:0]), "swirq");
      chk(int_req, |(eflg & ~ecw[5:0]) & ~ecw[7], "irq");
      chk(resp_infinity, m[3] | m[2], "inf");
      chk(resp_nan_sel, m[0] & !nan_operand, "nan_sel");
      chk(resp_nan_propagate, m[0] & nan_operand, "nan_prop");
      chk(resp_denormalize, m[4], "denorm");
      chk(resp_round, exc_detected[5], "round");
      chk(exec_stall, 1'b0, "stall");
      exc_detected = 6'h00;
      cc_op = 3'h0;
      // One idle edge keeps strobes from being lowered and raised in one step
      @(posedge clk);
      #2 chk({resp_infinity, resp_nan_sel, resp_nan_propagate, resp_denormalize, resp_round},
        5'h00, "resp_end");
    end
  endtask

  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  initial begin
    {rst_n, instr_done, operand_valid, nan_operand, exam_sign, rem_complete} = 6'h00;
    {quotient_bit_high, quotient_bit_mid, quotient_bit_low} = 3'h0;
    {instr_addr, operand_addr, instr_opcode, exc_detected, cc_op} = 60'h0;
    {cmp_result, exam_class, rem_range} = 7'h00;
    seed = 32'h33c3;
    errors = 0;
    n_checks = 0;
    ecw = 16'h033f;
    eflg = 6'h00;
    ecc = 4'h0;
    edp = 20'h0;
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    chk(cw_value, 16'h033f, "cw_rst");
    chk(sw_value, 16'h0000, "sw_rst");
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      r = rnd();
      ld({r[15:12], 2'(i), r[9:0]});
    end
    $display("control word test done");
    for (i = 0; i < 9; i++) begin
      r = rnd();
      cc_op = 3'h3;
      rem_complete = (i != 4);
      rem_range = 2'(i % 3);
      {quotient_bit_high, quotient_bit_mid, quotient_bit_low} = r[2:0];
      go;
    end
    for (i = 0; i < 4; i++) begin
      cc_op = 3'h1;
      cmp_result = 2'(i);
      go;
    end
    for (i = 0; i < 14; i++) begin
      cc_op = 3'h2;
      exam_class = 3'(i >> 1);
      exam_sign = i[0];
      go;
    end
    $display("condition test done");
    for (i = 0; i < 24; i++) begin
      r = rnd();
      if (i % 6 == 0) ld({ecw[15:8], r[7:0]});
      exc_detected = r[13:8] & r[21:16];
      nan_operand = r[22];
      go;
      if (r[23]) clr;
    end
    $display("exception test done");
    test_done;
  end

  initial begin
    #100000;
    errors = errors + 1;
    $display("[FAIL] watchdog expected end seen timeout");
    test_done;
  end
endmodule

// [testbench/fpu_ctl_sva.sv]
// Purpose: Checker for control word, flags, pointers and interrupt request
// Assumes: Bound to the top module, one clock domain
// Notes: Sees only top-level ports
`timescale 1ns/10ps
module fpu_ctl_sva #(
  parameter ADDR_W = 20,
  parameter OPC_W = 11
) (
  input wire clk,
  input wire rst_n,
  input wire cw_load,
  input wire [15:0] cw_load_data,
  input wire [15:0] cw_value,
  input wire [15:0] sw_value,
  input wire exc_clear,
  input wire instr_done,
  input wire [ADDR_W-1:0] instr_addr,
  input wire [OPC_W-1:0] instr_opcode,
  input wire [ADDR_W-1:0] instr_ptr,
  input wire [OPC_W-1:0] opcode_ptr,
  input wire [5:0] exc_detected,
  input wire [2:0] cc_op,
  input wire [1:0] cmp_result,
  input wire [1:0] round_mode,
  input wire [1:0] precision_mode,
  input wire affine_closure,
  input wire resp_infinity,
  input wire exec_stall,
  input wire int_req
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  cw_load_a: assert property (cw_load |=> cw_value == $past(cw_load_data))
    else $error("control word not loaded");
  cw_hold_a: assert property (!cw_load |=> $stable(cw_value))
    else $error("control word changed without load");
  mode_map_a: assert property (
    {affine_closure, round_mode, precision_mode} == cw_value[12:8])
    else $error("mode fields differ from control word");
  irq_bit_a: assert property (
    sw_value[7] == |(sw_value[5:0] & ~cw_value[5:0]))
    else $error("status request bit wrong");
  flag_set_a: assert property (
    instr_done && !exc_clear |=> &(sw_value[5:0] | ~$past(exc_detected)))
    else $error("detected exception not flagged");
  flag_clr_a: assert property (
    exc_clear && !instr_done |=> sw_value[5:0] == 6'h00 && !int_req)
    else $error("flags not cleared");
  irq_out_a: assert property (
    !$past(cw_load) |-> int_req == (sw_value[7] && !cw_value[7]))
    else $error("interrupt request wrong");
  cmp_cc_a: assert property (
    instr_done && cc_op == 3'h1 |=> sw_value[14] == $past(cmp_result[1])
    && sw_value[8] == $past(cmp_result[0]) && sw_value[10] == $past(&cmp_result)
    && $stable(sw_value[9]))
    else $error("compare flags wrong");
  ptr_save_a: assert property (
    instr_done |=> instr_ptr == $past(instr_addr) && opcode_ptr == $past(instr_opcode))
    else $error("pointers not saved");
  inf_resp_a: assert property (
    instr_done && |(exc_detected[3:2] & cw_value[3:2]) |=> resp_infinity)
    else $error("no infinity response");
  no_stall_a: assert property (!exec_stall)
    else $error("execution stalled");
  cover property (instr_done && cc_op == 3'h3);
  cover property (instr_done ##1 int_req);
  cover property (exc_clear && sw_value[7]);
endmodule

bind fpu_control_exception_flags fpu_ctl_sva #(.ADDR_W(ADDR_W), .OPC_W(OPC_W)) chk_i (
  .clk, .rst_n, .cw_load, .cw_load_data, .cw_value, .sw_value, .exc_clear, .instr_done,
  .instr_addr, .instr_opcode, .instr_ptr, .opcode_ptr, .exc_detected, .cc_op, .cmp_result,
  .round_mode,
  .precision_mode, .affine_closure, .resp_infinity, .exec_stall, .int_req);

// [testbench/host_model.sv]
// Purpose: Host side that loads the control word and clears exceptions
// Assumes: Tasks are entered just after a rising clock edge
// Notes: Data lines are scrambled outside a load
`timescale 1ns/10ps
module host_model (
  input wire clk,
  output logic cw_load,
  output logic [15:0] cw_load_data,
  output logic exc_clear
);
  initial begin
    cw_load = 1'b0;
    cw_load_data = 16'h0000;
    exc_clear = 1'b0;
  end
  // Always a whole word; the block has no byte-wide load
  task load(input [15:0] d);
    begin
      cw_load_data = d;
      cw_load = 1'b1;
      @(posedge clk);
      #2 cw_load = 1'b0;
      cw_load_data = ~d;
    end
  endtask
  task clr;
    begin
      exc_clear = 1'b1;
      @(posedge clk);
      #2 exc_clear = 1'b0;
    end
  endtask
endmodule
